// >>> clocked_fifo_flag_sync.sv
// Clocked FIFO with two port clocks sampled from pins and two-stage flag resynchronisation.
`default_nettype none
// Contract
// - Transfers only on port clock rise, enable-qualified.
// - Read while empty changes nothing.
// - Output-ready is empty resynchronised to read clock.
// - Input-ready is full resynchronised to write clock.
// - Flags pass two cascaded system-clocked stages, each advanced on a detected port clock rise.
// - Port clocks may be fully unrelated.
module clocked_fifo_flag_sync
  import fifo_flag_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = DATA_WIDTH_DEFAULT,
  parameter int unsigned ADDR_WIDTH = ADDR_WIDTH_DEFAULT
) (
  input  wire logic                  clk_in,
  input  wire logic                  rst_b_in,
  input  wire logic                  write_clk_in,
  input  wire logic                  write_en_in,
  input  wire logic [DATA_WIDTH-1:0] write_data_in,
  input  wire logic                  read_clk_in,
  input  wire logic                  read_en_in,
  output logic      [DATA_WIDTH-1:0] read_data_out,
  output logic                       input_ready_flag_out,
  output logic                       output_ready_flag_out
);
  // Neither port clock drives a flip-flop here. Both port clock pins, the enables and the
  // write data are sampled by the system clock through two flip-flops, and a port transfer
  // happens in the one system cycle in which a sampled port clock is seen to rise. The whole
  // block thus lives in one clock domain, and full and empty come from a plain comparison
  // of two positions with no gray-coded crossing.
  //
  // The price is speed: a port clock must stay high and stay low for longer than one system
  // clock period each, or a rise is missed and its transfer lost. A detected rise is acted on
  // two to three system clocks after the pin edge, and read data appear at that same
  // system clock edge.
  //
  // A change of full reaches the input-ready flag at the second detected write clock rise
  // after it, and a change of empty reaches the output-ready flag at the second detected read
  // clock rise. While a port clock stands still its flag does not move.
  //
  // The flags are status only. Writes and reads are guarded by the internal full and empty
  // conditions, so a lagging flag never causes an overwrite or a read of an unwritten cell;
  // a write taken while the input-ready flag is still low is therefore accepted if there is room.
  // The storage array has no reset; a cell is never read before it has been written.

  // Write port pin samples: two synchroniser stages and one delayed copy of the second.
  // The delayed copy holds what stood on the pins just before the port clock rose.
  typedef struct packed {
    logic                  wclk_s1;
    logic                  wclk_s2;
    logic                  wclk_d;
    logic                  wen_s1;
    logic                  wen_s2;
    logic                  wen_d;
    logic [DATA_WIDTH-1:0] wdata_s1;
    logic [DATA_WIDTH-1:0] wdata_s2;
    logic [DATA_WIDTH-1:0] wdata_d;

    // Read port pin samples, handled like the write side.
    logic                  rclk_s1;
    logic                  rclk_s2;
    logic                  rclk_d;
    logic                  ren_s1;
    logic                  ren_s2;
    logic                  ren_d;

    // Positions carry a wrap bit above the cell index so that full and empty differ.
    logic [ADDR_WIDTH:0]   wptr;
    logic [ADDR_WIDTH:0]   rptr;

    // Flag stages, each advanced only when its own port clock is seen to rise.
    logic                  ir_stage1;
    logic                  ir_stage2;
    logic                  or_stage1;
    logic                  or_stage2;
  } state_t;

  state_t state;
  state_t next_state;

  // The store sits behind an interface so that another array can replace it without touching this control.
  fifo_mem_if #(.DATA_WIDTH(DATA_WIDTH), .ADDR_WIDTH(ADDR_WIDTH)) mem ();

  fifo_store #(
    .DATA_WIDTH(DATA_WIDTH),
    .ADDR_WIDTH(ADDR_WIDTH)
  ) u_store (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .mem      (mem.store)
  );

  // Positions count modulo twice the depth; the top bit is the wrap bit.
  function automatic logic [ADDR_WIDTH:0] ptr_step(input logic [ADDR_WIDTH:0] ptr);
    ptr_step = ptr + {{ADDR_WIDTH{1'b0}}, 1'b1};
  endfunction

  // A sampled pin rose when its newer settled sample is high and the older one low.
  function automatic logic rise_seen(input logic newer, input logic older);
    rise_seen = newer && !older;
  endfunction

  // Equal positions, wrap bit included, mean that no word is stored.
  function automatic logic ptrs_empty(input logic [ADDR_WIDTH:0] wp, input logic [ADDR_WIDTH:0] rp);
    ptrs_empty = (wp == rp);
  endfunction

  // The same cell with opposite wrap bits means the writer is one whole lap ahead.
  function automatic logic ptrs_full(input logic [ADDR_WIDTH:0] wp, input logic [ADDR_WIDTH:0] rp);
    ptrs_full = (wp[ADDR_WIDTH] != rp[ADDR_WIDTH]) &&
                (wp[ADDR_WIDTH-1:0] == rp[ADDR_WIDTH-1:0]);
  endfunction

  // Decodes of the current state, used by the next-state logic below.
  logic wclk_rise;
  logic rclk_rise;
  logic fifo_empty;
  logic fifo_full;
  logic do_write;
  logic do_read;

  always_comb begin
    // Edges come from the second synchroniser stage and its delayed copy, never the first stage.
    wclk_rise  = rise_seen(state.wclk_s2, state.wclk_d);
    rclk_rise  = rise_seen(state.rclk_s2, state.rclk_d);
    fifo_empty = ptrs_empty(state.wptr, state.rptr);
    fifo_full  = ptrs_full(state.wptr, state.rptr);
    // The delayed copies hold enable and data as they stood just before the port clock rose.
    // A write against a full store is dropped, so no stored word is ever overwritten.
    do_write   = wclk_rise && state.wen_d && !fifo_full;
    // A read against an empty store is dropped, so neither the position nor the output
    // register moves.
    do_read    = rclk_rise && state.ren_d && !fifo_empty;
  end

  always_comb begin
    next_state          = state;

    // Write port pins shift one stage per system clock.
    next_state.wclk_s1  = write_clk_in;
    next_state.wclk_s2  = state.wclk_s1;
    next_state.wclk_d   = state.wclk_s2;
    next_state.wen_s1   = write_en_in;
    next_state.wen_s2   = state.wen_s1;
    next_state.wen_d    = state.wen_s2;
    next_state.wdata_s1 = write_data_in;
    next_state.wdata_s2 = state.wdata_s1;
    next_state.wdata_d  = state.wdata_s2;

    // Read port pins, the same way.
    next_state.rclk_s1  = read_clk_in;
    next_state.rclk_s2  = state.rclk_s1;
    next_state.rclk_d   = state.rclk_s2;
    next_state.ren_s1   = read_en_in;
    next_state.ren_s2   = state.ren_s1;
    next_state.ren_d    = state.ren_s2;

    // Positions move only on an accepted transfer.
    if (do_write) begin
      next_state.wptr = ptr_step(state.wptr);
    end
    if (do_read) begin
      next_state.rptr = ptr_step(state.rptr);
    end

    // Each flag moves one stage per rising edge of its own port clock, so a change
    // of full or empty takes two port clock edges to reach the pin.
    // The first stage cannot go metastable: the status and both stages are system-clocked, and
    // the second stage takes the first stage a whole port clock period after it was loaded.
    if (wclk_rise) begin
      next_state.ir_stage1 = !fifo_full;
      next_state.ir_stage2 = state.ir_stage1;
    end
    if (rclk_rise) begin
      next_state.or_stage1 = !fifo_empty;
      next_state.or_stage2 = state.or_stage1;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      // A port clock that stands high at release shows one rise, but the enable samples are
      // clear then, so that rise carries no transfer.
      state.wclk_s1   <= PIN_RESET;
      state.wclk_s2   <= PIN_RESET;
      state.wclk_d    <= PIN_RESET;
      state.wen_s1    <= PIN_RESET;
      state.wen_s2    <= PIN_RESET;
      state.wen_d     <= PIN_RESET;
      state.wdata_s1  <= '0;
      state.wdata_s2  <= '0;
      state.wdata_d   <= '0;

      state.rclk_s1   <= PIN_RESET;
      state.rclk_s2   <= PIN_RESET;
      state.rclk_d    <= PIN_RESET;
      state.ren_s1    <= PIN_RESET;
      state.ren_s2    <= PIN_RESET;
      state.ren_d     <= PIN_RESET;

      state.wptr      <= '0;
      state.rptr      <= '0;

      state.ir_stage1 <= FLAG_RESET;
      state.ir_stage2 <= FLAG_RESET;
      state.or_stage1 <= FLAG_RESET;
      state.or_stage2 <= FLAG_RESET;
    end else begin
      state <= next_state;
    end
  end

  // The store sees accepted transfers only.
  assign mem.write_en   = do_write;
  assign mem.write_addr = state.wptr[ADDR_WIDTH-1:0];
  assign mem.write_data = state.wdata_d;
  assign mem.read_en    = do_read;
  assign mem.read_addr  = state.rptr[ADDR_WIDTH-1:0];

  // Read data come from the store's output register, the flags from their second stage.
  assign read_data_out         = mem.read_data;
  assign input_ready_flag_out  = state.ir_stage2;
  assign output_ready_flag_out = state.or_stage2;
endmodule
`default_nettype wire

// >>> clocked_fifo_flag_sync_props.sv
// Timing checks on the FIFO pins.
`default_nettype none
module clocked_fifo_flag_sync_props #(parameter int unsigned DATA_WIDTH = 9) (
  input wire logic                  clk_in,
  input wire logic                  rst_b_in,
  input wire logic                  write_clk_in,
  input wire logic                  read_clk_in,
  input wire logic                  read_en_in,
  input wire logic [DATA_WIDTH-1:0] read_data_out,
  input wire logic                  input_ready_flag_out,
  input wire logic                  output_ready_flag_out
);
  logic [15:0] wh, rh;
  logic [14:0] wr, rr;
  assign wr = wh[14:0] & ~wh[15:1];
  assign rr = rh[14:0] & ~rh[15:1];
  // Pin history mirrors the edge detection inside the block.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) {wh, rh} <= '0;
    else {wh, rh} <= {wh[14:0], write_clk_in, rh[14:0], read_clk_in};
  end
  logic [1:0] wseen, rseen;
  // Detected port rises since reset, stopping at three; a flag needs two to rise.
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wseen <= 2'h0;
      rseen <= 2'h0;
    end else begin
      if (wr[1] && wseen != 2'h3) wseen <= wseen + 2'h1;
      if (rr[1] && rseen != 2'h3) rseen <= rseen + 2'h1;
    end
  end
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  property p_rd; $changed(read_data_out) |-> |rr[7:0]; endproperty
  a_rd: assert property (p_rd) else $error("read data off edge");
  property p_en; $changed(read_data_out) |-> $past(read_en_in, 6); endproperty
  a_en: assert property (p_en) else $error("read without enable");
  property p_or; $changed(output_ready_flag_out) |-> |rr[7:0]; endproperty
  a_or: assert property (p_or) else $error("output flag off edge");
  property p_ir; $changed(input_ready_flag_out) |-> |wr[7:0]; endproperty
  a_ir: assert property (p_ir) else $error("input flag off edge");
  property p_two; $rose(output_ready_flag_out) |-> $countones(rr) > 1; endproperty
  a_two: assert property (p_two) else $error("output flag too early");
  property p_ir_two; input_ready_flag_out |-> wseen >= 2'h2; endproperty
  a_ir_two: assert property (p_ir_two) else $error("input flag before two write rises");
  property p_or_two; output_ready_flag_out |-> rseen >= 2'h2; endproperty
  a_or_two: assert property (p_or_two) else $error("output flag before two read rises");
  c_full: cover property ($fell(input_ready_flag_out));
  c_empty: cover property ($fell(output_ready_flag_out));
  c_read: cover property ($changed(read_data_out));
endmodule
bind clocked_fifo_flag_sync clocked_fifo_flag_sync_props #(.DATA_WIDTH(DATA_WIDTH)) chk (
  .clk_in                (clk_in),
  .rst_b_in              (rst_b_in),
  .write_clk_in          (write_clk_in),
  .read_clk_in           (read_clk_in),
  .read_en_in            (read_en_in),
  .read_data_out         (read_data_out),
  .input_ready_flag_out  (input_ready_flag_out),
  .output_ready_flag_out (output_ready_flag_out)
);
`default_nettype wire

// >>> fifo_flag_pkg.sv
// Shared constants for the clocked FIFO with resynchronised flags.
`default_nettype none
package fifo_flag_pkg;
  localparam int unsigned DATA_WIDTH_DEFAULT = 9;
  localparam int unsigned ADDR_WIDTH_DEFAULT = 4;
  localparam logic        FLAG_RESET         = 1'h0;
  localparam logic        PIN_RESET          = 1'h0;
endpackage
`default_nettype wire

// >>> fifo_mem_if.sv
// Interface joining the FIFO control to its storage array.
`default_nettype none
interface fifo_mem_if #(
  parameter int unsigned DATA_WIDTH = 9,
  parameter int unsigned ADDR_WIDTH = 4
);
  logic                  write_en;
  logic [ADDR_WIDTH-1:0] write_addr;
  logic [DATA_WIDTH-1:0] write_data;
  logic                  read_en;
  logic [ADDR_WIDTH-1:0] read_addr;
  logic [DATA_WIDTH-1:0] read_data;

  modport ctrl (
    output write_en,
    output write_addr,
    output write_data,
    output read_en,
    output read_addr,
    input  read_data
  );

  modport store (
    input  write_en,
    input  write_addr,
    input  write_data,
    input  read_en,
    input  read_addr,
    output read_data
  );
endinterface
`default_nettype wire

// >>> fifo_store.sv
// Storage array of the FIFO with a registered read port.
`default_nettype none
module fifo_store
  import fifo_flag_pkg::*;
#(
  parameter int unsigned DATA_WIDTH = DATA_WIDTH_DEFAULT,
  parameter int unsigned ADDR_WIDTH = ADDR_WIDTH_DEFAULT
) (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  fifo_mem_if.store mem
);
  localparam int unsigned DEPTH = 1 << ADDR_WIDTH;

  logic [DATA_WIDTH-1:0] cells [DEPTH];
  logic [DATA_WIDTH-1:0] read_reg;

  // The array itself has no reset; only the output register is cleared.
  always_ff @(posedge clk_in) begin
    if (mem.write_en) begin
      cells[mem.write_addr] <= mem.write_data;
    end
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      read_reg <= '0;
    end else if (mem.read_en) begin
      read_reg <= cells[mem.read_addr];
    end
  end

  assign mem.read_data = read_reg;
endmodule
`default_nettype wire

// >>> port_logic_model.sv
// System logic on both ports: free-running port clocks and enables.
`default_nettype none
module port_logic_model (
  input  wire logic       wq_in,
  input  wire logic [8:0] wd_in,
  input  wire logic       rq_in,
  output logic            wclk_out = 1'h0,
  output logic            wen_out = 1'h0,
  output logic [8:0]      wdat_out = 9'h000,
  output logic            rclk_out = 1'h0,
  output logic            ren_out = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  // Phases differ so no port edge meets a system clock edge.
  initial #137 forever #200 wclk_out = ~wclk_out;
  initial #83 forever #200 rclk_out = ~rclk_out;
  always @(posedge wclk_out) begin
    wen_out <= wq_in;
    wdat_out <= wq_in ? wd_in : ~wdat_out;
  end
  always @(posedge rclk_out) ren_out <= rq_in;
endmodule
`default_nettype wire

// >>> tb.sv
// Bench for the FIFO with resynchronised flags.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk_in = 1'h0, rst_b_in = 1'h0, wq = 1'h0, rq = 1'h0, write_clk_in, write_en_in;
  logic       read_clk_in, read_en_in, input_ready_flag_out, output_ready_flag_out;
  logic [8:0] wd = 9'h000, last = 9'h000, read_data_out, write_data_in, q[$];
  int         bad_count = 0, n_compared = 0, cycles = 0;
  port_logic_model far (.wq_in(wq), .wd_in(wd), .rq_in(rq), .wclk_out(write_clk_in), .wen_out(write_en_in),
    .wdat_out(write_data_in), .rclk_out(read_clk_in), .ren_out(read_en_in));
  clocked_fifo_flag_sync uut (
    .clk_in                (clk_in),
    .rst_b_in              (rst_b_in),
    .write_clk_in          (write_clk_in),
    .write_en_in           (write_en_in),
    .write_data_in         (write_data_in),
    .read_clk_in           (read_clk_in),
    .read_en_in            (read_en_in),
    .read_data_out         (read_data_out),
    .input_ready_flag_out  (input_ready_flag_out),
    .output_ready_flag_out (output_ready_flag_out)
  );
  initial forever #25 clk_in = ~clk_in;
  always @(posedge clk_in) if (++cycles == 4000) begin
    bad_count++;
    complete_run();
  end
  task automatic check(input logic [8:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("compared %0d bad %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  function automatic logic [8:0] exp_ir(int held);
    return {8'h00, held < 16};
  endfunction
  // A request set before one port edge is carried out at the following edge.
  task automatic xfer(input bit wr, input int cnt);
    logic [8:0] v;
    for (int i = 0; i <= cnt; i++) begin
      v = i % 5 ? 9'($urandom) : 9'h1FF;
      @(posedge clk_in);
      if (wr && i < cnt && q.size() < 16) q.push_back(v);
      if (wr) wq <= i < cnt;
      else rq <= i < cnt;
      wd <= v;
      @(posedge (wr ? write_clk_in : read_clk_in));
      repeat (7) @(posedge clk_in);
      if (!wr && i > 0) begin
        if (q.size() > 0) last = q.pop_front();
        check(read_data_out, last);
      end
    end
  endtask
  initial begin
    int n;
    void'($urandom(14363));
    repeat (4) @(posedge clk_in);
    rst_b_in <= 1'h1;
    xfer(0, 2);
    for (int k = 0; k < 3; k++) begin
      n = k == 0 ? 20 : $urandom_range(16, 1);
      xfer(1, n);
      repeat (40) @(posedge clk_in);
      check(input_ready_flag_out, exp_ir(q.size()));
      check(output_ready_flag_out, 9'h001);
      xfer(0, n + 2);
      repeat (40) @(posedge clk_in);
      check(output_ready_flag_out, 9'h000);
      check(input_ready_flag_out, 9'h001);
    end
    complete_run();
  end
endmodule
`default_nettype wire
